// [sas_smoke_alarm_sequencer.sv]
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module sas_smoke_alarm_sequencer
   import sas_pkg::*;
#(
   parameter int OSC_CYC = OSC_CYC_DEF,
   parameter int EMIT_CYC = EMIT_CYC_DEF,
   parameter int SLOW_OSC = LED_SLOW_OSC,
   parameter int HUSH_OSC = HUSH_OSC_DEF,
   parameter int CARRIER_BIT = CARRIER_BIT_DEF
)(
   input wire logic clk,
   input wire logic reset,
   input wire sas_in_t pins,
   output sas_out_t drv,
   input wire sas_axi_req_t axiReq,
   output sas_axi_rsp_t axiRsp
);

   typedef struct packed {
      logic [5:0] sy1;
      logic [5:0] sy2;
      logic [5:0] sy3;
      logic [5:0] pin;
      logic [31:0] divCnt;
      sas_cnt_t smpCnt;
      sas_cnt_t ledCnt;
      sas_cnt_t ioCnt;
      sas_cnt_t trbCnt;
      sas_cnt_t hushCnt;
      sas_cnt_t chirpCnt;
      logic [MOD_W-1:0] modCnt;
      sas_mode_t mode;
      sas_kind_t kind;
      logic speedUp;
      logic alarmMem;
      logic testAlarm;
      logic released;
      logic ioFlag;
      logic ioConfirm;
      logic btnPrev;
      logic ioPrev;
      logic lowFail;
      logic chamberFail;
      logic chirpOn;
      logic ioDisable;
      logic [1:0] testPulses;
      logic [1:0] relPulses;
      logic awHeld;
      logic wHeld;
      logic [ADDR_W-1:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      sas_out_t out;
      sas_axi_rsp_t rsp;
   } sas_state_t;

   localparam sas_state_t RESET_STATE = '0;

   sas_state_t s_q;
   sas_state_t s_d;
   sas_in_t p;
   logic tick;
   logic btnRise;
   logic btnFall;
   logic ioRise;
   logic ledDue;
   logic quiet;
   logic tone;
   logic carrier;

   assign drv = s_q.out;
   assign axiRsp = s_q.rsp;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      ledDue = 1'b0;
      quiet = 1'b0;
      tone = 1'b0;
      carrier = 1'b0;

      // Pin inputs: a change counts once the second and third stages agree
      s_d.sy1 = pins;
      s_d.sy2 = s_q.sy1;
      s_d.sy3 = s_q.sy2;
      s_d.pin = (~(s_q.sy2 ^ s_q.sy3) & s_q.sy2) |
                ((s_q.sy2 ^ s_q.sy3) & s_q.pin);
      p = sas_in_t'(s_q.pin);

      // Timebase divider; every interval below counts its periods
      tick = (s_q.divCnt == 32'(OSC_CYC - 1));
      s_d.divCnt = tick ? 32'h0 : s_q.divCnt + 32'h1;

      ///////////////////////////////////////////////////////////////////
      // Register bus: write address and data may arrive in either order
      if (axiReq.awvalid && s_q.rsp.awready) begin
         s_d.awHeld = 1'b1;
         s_d.awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && s_q.rsp.wready) begin
         s_d.wHeld = 1'b1;
         s_d.wData = axiReq.wdata;
         s_d.wStrb = axiReq.wstrb;
      end
      if (s_q.rsp.bvalid && axiReq.bready) begin
         s_d.rsp.bvalid = 1'b0;
      end
      if (s_q.awHeld && s_q.wHeld && !s_q.rsp.bvalid) begin
         s_d.awHeld = 1'b0;
         s_d.wHeld = 1'b0;
         s_d.rsp.bvalid = 1'b1;
         s_d.rsp.bresp = RESP_OKAY;
         if (s_q.awAddr == REG_CTRL) begin
            if (s_q.wStrb[0]) begin
               s_d.ioDisable = s_q.wData[CTRL_IODIS_BIT];
               // Hardware setting the memory later this cycle still wins
               if (s_q.wData[CTRL_CLRMEM_BIT]) begin
                  s_d.alarmMem = 1'b0;
               end
            end
         end else if (s_q.awAddr == REG_STATUS) begin
            s_d.rsp.bresp = RESP_OKAY;
         end else begin
            s_d.rsp.bresp = RESP_DECERR;
         end
      end
      if (s_q.rsp.rvalid && axiReq.rready) begin
         s_d.rsp.rvalid = 1'b0;
      end
      if (axiReq.arvalid && s_q.rsp.arready) begin
         s_d.rsp.rvalid = 1'b1;
         s_d.rsp.rresp = RESP_OKAY;
         s_d.rsp.rdata = 32'h0;
         if (axiReq.araddr == REG_CTRL) begin
            s_d.rsp.rdata[CTRL_IODIS_BIT] = s_q.ioDisable;
         end else if (axiReq.araddr == REG_STATUS) begin
            s_d.rsp.rdata[STAT_MODE_LSB +: 3] = s_q.mode;
            s_d.rsp.rdata[STAT_MEM_BIT] = s_q.alarmMem;
            s_d.rsp.rdata[STAT_SPEEDUP_BIT] = s_q.speedUp;
            s_d.rsp.rdata[STAT_LOWFAIL_BIT] = s_q.lowFail;
            s_d.rsp.rdata[STAT_CHAMBFAIL_BIT] = s_q.chamberFail;
            s_d.rsp.rdata[STAT_TESTALARM_BIT] = s_q.testAlarm;
         end else begin
            s_d.rsp.rresp = RESP_DECERR;
         end
      end

      ///////////////////////////////////////////////////////////////////
      // Work done once per timebase period
      if (tick) begin
         s_d.modCnt = s_q.modCnt + 5'h01;
         s_d.chirpOn = 1'b0;

         // Strobe ends: judge the comparator result of this test
         if (s_q.out.strobe) begin
            s_d.out.strobe = 1'b0;
            if (s_q.kind == K_CHAMBER) begin
               // High gain must see chamber background; none means degraded
               s_d.chamberFail = ~p.smokeCmp;
            end else begin
               case (s_q.mode)
                  ST_STANDBY, ST_REMOTE: begin
                     if (p.smokeCmp) begin
                        if (s_q.speedUp || s_q.mode == ST_REMOTE) begin
                           s_d.mode = ST_SMOKE;
                        end
                        s_d.speedUp = 1'b1;
                     end else begin
                        s_d.speedUp = 1'b0;
                     end
                  end
                  ST_SMOKE: begin
                     if (!p.smokeCmp) begin
                        s_d.mode = ST_STANDBY;
                        s_d.speedUp = 1'b0;
                        s_d.alarmMem = 1'b1;
                     end
                  end
                  ST_HUSH: begin
                     if (!p.smokeCmp) begin
                        s_d.mode = ST_STANDBY;
                        s_d.speedUp = 1'b0;
                        s_d.hushCnt = '0;
                        s_d.alarmMem = 1'b1;
                     end else if (p.highSmokeCmp) begin
                        s_d.mode = ST_SMOKE;
                        s_d.hushCnt = '0;
                     end
                  end
                  ST_TEST: begin
                     if (s_q.testPulses != 2'h3) begin
                        s_d.testPulses = s_q.testPulses + 2'h1;
                     end
                     if (p.smokeCmp && s_q.testPulses != 2'h0 &&
                         !s_q.released) begin
                        s_d.testAlarm = 1'b1;
                     end
                     if (s_q.released) begin
                        s_d.relPulses = s_q.relPulses + 2'h1;
                        if (s_q.relPulses == 2'h1) begin
                           s_d.mode = ST_STANDBY;
                           s_d.testAlarm = 1'b0;
                           s_d.released = 1'b0;
                        end
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end

         // Low-supply load lasts one period; result taken as it ends
         if (s_q.out.lowSupplyLoad) begin
            s_d.out.lowSupplyLoad = 1'b0;
            s_d.lowFail = p.lowSupplyCmp;
         end

         // Confirming interconnect sample one period after the first
         if (s_q.ioConfirm) begin
            s_d.ioConfirm = 1'b0;
            if (p.ioLine && (s_d.mode == ST_STANDBY ||
                             s_d.mode == ST_HUSH)) begin
               s_d.mode = ST_REMOTE;
               s_d.hushCnt = '0;
            end
         end

         if (s_q.ioCnt == '0) begin
            s_d.ioCnt = CNT_W'(IO_SAMPLE_OSC - 1);
            if ((s_q.mode == ST_STANDBY || s_q.mode == ST_HUSH) &&
                s_q.ioFlag) begin
               s_d.ioConfirm = 1'b1;
               s_d.ioFlag = 1'b0;
            end
            if (s_d.mode == ST_REMOTE && !p.ioLine) begin
               s_d.mode = ST_STANDBY;
            end
         end else begin
            s_d.ioCnt = s_q.ioCnt - 16'h0001;
         end

         // Hush window timeout returns to the sounding alarm
         if (s_d.mode == ST_HUSH) begin
            if (s_q.hushCnt <= 16'h0001) begin
               s_d.mode = ST_SMOKE;
               s_d.hushCnt = '0;
            end else begin
               s_d.hushCnt = s_q.hushCnt - 16'h0001;
            end
         end

         // Smoke or test sampling
         if (s_q.smpCnt == '0) begin
            if (s_d.mode == ST_TEST) begin
               s_d.smpCnt = CNT_W'(TEST_PULSE_OSC - 1);
            end else if (s_d.speedUp || s_d.mode == ST_SMOKE ||
                         s_d.mode == ST_HUSH) begin
               s_d.smpCnt = CNT_W'(SPEEDUP_OSC - 1);
            end else begin
               s_d.smpCnt = CNT_W'(STANDBY_OSC - 1);
            end
            if (s_d.mode != ST_MEMCHIRP && !s_q.out.strobe) begin
               s_d.out.strobe = 1'b1;
               s_d.kind = K_SMOKE;
            end
         end else begin
            s_d.smpCnt = s_q.smpCnt - 16'h0001;
         end

         // Trouble tests, spread apart so none overlap
         s_d.trbCnt = (s_q.trbCnt == '0) ? CNT_W'(SLOW_OSC - 1) :
                      s_q.trbCnt - 16'h0001;
         quiet = (s_d.mode == ST_STANDBY) && !s_d.speedUp &&
                 !s_q.out.hornBrass && !s_q.out.hornSilver;
         if (s_q.trbCnt == '0 && quiet && !s_q.out.strobe &&
             !s_d.out.strobe) begin
            s_d.out.strobe = 1'b1;
            s_d.kind = K_CHAMBER;
         end
         if (s_q.trbCnt == CNT_W'(SLOW_OSC / LOWSUP_DIV) && quiet &&
             !s_q.out.strobe && !s_d.out.strobe && !s_q.chirpOn) begin
            s_d.out.lowSupplyLoad = 1'b1;
         end
         if (s_q.trbCnt == CNT_W'(SLOW_OSC / TROUBLE_CHIRP_DIV) && quiet &&
             (s_q.lowFail || s_q.chamberFail)) begin
            s_d.chirpOn = 1'b1;
         end

         // Alarm memory chirps while the button is held
         if (s_q.mode == ST_MEMCHIRP) begin
            if (s_q.chirpCnt == '0) begin
               s_d.chirpOn = 1'b1;
               s_d.chirpCnt = CNT_W'(MEM_CHIRP_OSC - 1);
            end else begin
               s_d.chirpCnt = s_q.chirpCnt - 16'h0001;
            end
         end

         // Lamp pulse, one period wide
         if (s_q.ledCnt == '0) begin
            ledDue = 1'b1;
            if (s_d.mode == ST_STANDBY || s_d.mode == ST_REMOTE) begin
               s_d.ledCnt = CNT_W'(SLOW_OSC - 1);
            end else begin
               s_d.ledCnt = CNT_W'(LED_FAST_OSC - 1);
            end
         end else begin
            s_d.ledCnt = s_q.ledCnt - 16'h0001;
         end
         s_d.out.lampOe = ledDue && (s_d.mode != ST_REMOTE);

         // In test, gain follows the button one period late, or a chamber test
         s_d.out.highGainSelect = (s_d.mode == ST_TEST && p.btnHigh) ||
            (s_d.out.strobe && s_d.kind == K_CHAMBER);
      end

      ///////////////////////////////////////////////////////////////////
      // Button and interconnect events, every clock
      btnRise = p.btnHigh && !s_q.btnPrev;
      btnFall = !p.btnHigh && s_q.btnPrev;
      s_d.btnPrev = p.btnHigh;
      ioRise = p.ioLine && !s_q.ioPrev;
      s_d.ioPrev = p.ioLine;
      // Own drive would read back as an edge, so it is ignored
      if (ioRise && !s_q.out.ioOe) begin
         s_d.ioFlag = 1'b1;
      end

      if (btnRise) begin
         if (s_q.alarmMem && s_q.mode == ST_STANDBY) begin
            s_d.mode = ST_MEMCHIRP;
            s_d.chirpCnt = '0;
         end else begin
            s_d.mode = ST_TEST;
            s_d.hushCnt = '0;
            s_d.smpCnt = '0;
            s_d.testPulses = 2'h0;
            s_d.relPulses = 2'h0;
            s_d.released = 1'b0;
            s_d.testAlarm = 1'b0;
         end
      end else if (btnFall) begin
         if (s_q.mode == ST_MEMCHIRP) begin
            s_d.mode = ST_STANDBY;
            s_d.alarmMem = 1'b0;
         end else if (s_q.mode == ST_TEST) begin
            s_d.released = 1'b1;
            s_d.relPulses = 2'h0;
         end
      end else if (p.btnMid && !p.btnHigh && s_q.mode == ST_SMOKE) begin
         // Outside smoke the mid-level request simply does nothing
         s_d.mode = ST_HUSH;
         s_d.hushCnt = CNT_W'(HUSH_OSC);
      end

      ///////////////////////////////////////////////////////////////////
      // Pin drive
      s_d.out.infraredEmitterDrive = s_d.out.strobe &&
         (s_d.divCnt >= 32'(OSC_CYC - EMIT_CYC));
      // Hush leaves the tone off while smoke is still present
      tone = ((s_d.mode == ST_SMOKE || s_d.mode == ST_REMOTE ||
               s_d.testAlarm) &&
              (s_d.modCnt < MOD_W'(MOD_ON_OSC))) ||
             s_d.chirpOn;
      carrier = s_d.divCnt[CARRIER_BIT];
      s_d.out.hornBrass = tone && carrier;
      s_d.out.hornSilver = tone && !carrier;
      s_d.out.lampOut = 1'b0;
      s_d.out.ioOut = 1'b1;
      s_d.out.ioOe = (s_d.mode == ST_SMOKE || s_d.testAlarm) &&
                     !s_d.ioDisable;

      s_d.rsp.awready = !s_d.awHeld && !s_d.rsp.bvalid;
      s_d.rsp.wready = !s_d.wHeld && !s_d.rsp.bvalid;
      s_d.rsp.arready = !s_d.rsp.rvalid;
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= RESET_STATE;
      end else begin
         s_q <= s_d;
      end
   end

endmodule

// [sas_pkg.sv]
package sas_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Clock and timebase
   localparam int CLK_PERIOD_NS = 4;
   localparam int OSC_PERIOD_US = 7900;
   localparam int EMIT_WIDTH_US = 105;
   localparam int OSC_CYC_DEF = OSC_PERIOD_US * 1000 / CLK_PERIOD_NS;
   localparam int EMIT_CYC_DEF = EMIT_WIDTH_US * 1000 / CLK_PERIOD_NS;
   localparam int CARRIER_BIT_DEF = 16;

   // Interval in milliseconds to whole timebase periods, at least one
   function automatic int msToOsc(input int ms);
      int c;
      c = (ms * 1000) / OSC_PERIOD_US;
      msToOsc = (c < 1) ? 1 : c;
   endfunction

   localparam int SPEEDUP_MS = 2000;
   localparam int STANDBY_MS = 8000;
   localparam int IO_SAMPLE_MS = 1000;
   localparam int TEST_PULSE_MS = 1000;
   localparam int LED_FAST_MS = 2000;
   localparam int LED_SLOW_MS = 32400;
   localparam int MEM_CHIRP_MS = 250;
   localparam int HUSH_MS = 480000;
   localparam int SPEEDUP_OSC = msToOsc(SPEEDUP_MS);
   localparam int STANDBY_OSC = msToOsc(STANDBY_MS);
   localparam int IO_SAMPLE_OSC = msToOsc(IO_SAMPLE_MS);
   localparam int TEST_PULSE_OSC = msToOsc(TEST_PULSE_MS);
   localparam int LED_FAST_OSC = msToOsc(LED_FAST_MS);
   localparam int LED_SLOW_OSC = msToOsc(LED_SLOW_MS);
   localparam int MEM_CHIRP_OSC = msToOsc(MEM_CHIRP_MS);
   localparam int HUSH_OSC_DEF = msToOsc(HUSH_MS);
   localparam int MOD_PERIOD_OSC = 32;
   localparam int MOD_ON_PCT = 75;
   localparam int MOD_ON_OSC = MOD_PERIOD_OSC * MOD_ON_PCT / 100;
   localparam int LOWSUP_DIV = 2;
   localparam int TROUBLE_CHIRP_DIV = 4;

   localparam int CNT_W = 16;
   localparam int MOD_W = 5;
   typedef logic [CNT_W-1:0] sas_cnt_t;

   ////////////////////////////////////////////////////////////////////////
   // Register map
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam int CTRL_CLRMEM_BIT = 0;
   localparam int CTRL_IODIS_BIT = 1;
   localparam logic CTRL_IODIS_RESET = 1'b0;
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_MEM_BIT = 3;
   localparam int STAT_SPEEDUP_BIT = 4;
   localparam int STAT_LOWFAIL_BIT = 5;
   localparam int STAT_CHAMBFAIL_BIT = 6;
   localparam int STAT_TESTALARM_BIT = 7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [2:0] {
      ST_STANDBY = 3'h0,
      ST_SMOKE = 3'h1,
      ST_HUSH = 3'h3,
      ST_REMOTE = 3'h2,
      ST_TEST = 3'h6,
      ST_MEMCHIRP = 3'h7
   } sas_mode_t;

   typedef enum logic {
      K_SMOKE = 1'b0,
      K_CHAMBER = 1'b1
   } sas_kind_t;

   typedef struct packed {
      logic ioLine;
      logic btnHigh;
      logic btnMid;
      logic smokeCmp;
      logic highSmokeCmp;
      logic lowSupplyCmp;
   } sas_in_t;

   typedef struct packed {
      logic strobe;
      logic infraredEmitterDrive;
      logic highGainSelect;
      logic hornBrass;
      logic hornSilver;
      logic lampOut;
      logic lampOe;
      logic ioOut;
      logic ioOe;
      logic lowSupplyLoad;
   } sas_out_t;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } sas_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sas_axi_rsp_t;

endpackage

// [sas_peer_units.sv]
`timescale 1ns/1ps
module sas_peer_units #(
   parameter int LAG = 2
)(
   input wire logic clk,
   input wire logic send,
   input wire logic dutOe,
   input wire logic dutOut,
   output logic line
);
   logic [LAG-1:0] dly_q = '0;
   // LAG sets how slowly the other units answer; at least 2
   always @(posedge clk) dly_q <= {dly_q[LAG-2:0], send};
   // Sink pulls the line low once every unit lets go
   assign line = dly_q[LAG-1] | (dutOe & dutOut);
endmodule

// [sas_smoke_alarm_sequencer_sva.sv]
`timescale 1ns/1ps
module sas_smoke_alarm_sequencer_sva
   import sas_pkg::*;
#(
   parameter int OSC_CYC = OSC_CYC_DEF,
   parameter int EMIT_CYC = EMIT_CYC_DEF
)(
   input wire logic clk,
   input wire logic reset,
   input wire sas_in_t pins,
   input wire sas_out_t drv,
   input wire sas_axi_req_t axiReq,
   input wire sas_axi_rsp_t axiRsp
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   int sCnt_q, lCnt_q, qCnt_q, gCnt_q;
   logic horn;
   assign horn = drv.hornBrass | drv.hornSilver;
   // Run lengths; long counts cannot be unrolled in a property
   always_ff @(posedge clk) begin
      sCnt_q <= (drv.strobe && !reset) ? sCnt_q + 1 : 0;
      lCnt_q <= (drv.lampOe && !reset) ? lCnt_q + 1 : 0;
      qCnt_q <= (drv.ioOe && !horn && !reset) ? qCnt_q + 1 : 0;
      gCnt_q <= (drv.highGainSelect && !pins.btnHigh && !reset) ?
         gCnt_q + 1 : 0;
   end
   a_emit_tail: assert property (
      drv.strobe && !drv.lowSupplyLoad |->
      drv.infraredEmitterDrive == (sCnt_q >= OSC_CYC - EMIT_CYC))
      else $error("emitter not at strobe tail");
   a_emit_inside: assert property (
      drv.infraredEmitterDrive |-> drv.strobe)
      else $error("emitter outside strobe");
   a_strobe_width: assert property (
      $fell(drv.strobe) |-> sCnt_q == OSC_CYC)
      else $error("strobe width wrong");
   a_lamp_width: assert property (
      $fell(drv.lampOe) |-> lCnt_q == OSC_CYC && !$past(drv.lampOut))
      else $error("lamp pulse wrong");
   a_io_reset: assert property (disable iff (1'b0)
      reset |=> !drv.ioOe)
      else $error("interconnect driven in reset");
   a_horn_anti: assert property (
      horn |-> drv.hornBrass != drv.hornSilver)
      else $error("horn not antiphase");
   a_load_alone: assert property (
      drv.lowSupplyLoad |-> !drv.infraredEmitterDrive && !horn && !drv.ioOe)
      else $error("test load overlaps");
   a_tone_gap: assert property (
      qCnt_q <= 8 * OSC_CYC)
      else $error("alarm tone gap too long");
   a_gain_drop: assert property (
      gCnt_q <= OSC_CYC + 6)
      else $error("gain not restored");
   c_emit: cover property (drv.infraredEmitterDrive);
   c_io: cover property ($rose(drv.ioOe));
   c_load: cover property (drv.lowSupplyLoad);
   c_bus: cover property (axiRsp.bvalid && axiReq.bready);
endmodule

bind sas_smoke_alarm_sequencer sas_smoke_alarm_sequencer_sva #(
   .OSC_CYC(OSC_CYC),
   .EMIT_CYC(EMIT_CYC)
) chk_u (
   .clk(clk),
   .reset(reset),
   .pins(pins),
   .drv(drv),
   .axiReq(axiReq),
   .axiRsp(axiRsp)
);

// [test_smoke_alarm_sequencer.sv]
`timescale 1ns/1ps
module test_smoke_alarm_sequencer import sas_pkg::*;;
   localparam int OSC = 16;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic send = 1'b0;
   logic line;
   sas_in_t pinsDrv = '0;
   sas_in_t pins;
   sas_out_t drv;
   sas_axi_req_t axiReq = '0;
   sas_axi_rsp_t axiRsp;
   logic [33:0] noteQ[$], maskQ[$], mSeen, mExp, mMask;
   int num_errors = 0;
   int checks = 0;
   int seed = 53706;
   int cyc = 0;
   int lamps, horns, t0;
   logic [31:0] d;
   always #2 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   always_comb begin
      pins = pinsDrv;
      pins.ioLine = line;
   end
   sas_smoke_alarm_sequencer #(.OSC_CYC(OSC), .EMIT_CYC(4), .SLOW_OSC(64),
      .HUSH_OSC(300), .CARRIER_BIT(1)) dut_u (.clk(clk), .reset(reset),
      .pins(pins), .drv(drv), .axiReq(axiReq), .axiRsp(axiRsp));
   sas_peer_units #(.LAG(2)) peer_u (.clk(clk), .send(send),
      .dutOe(drv.ioOe), .dutOut(drv.ioOut), .line(line));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (num_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic fail();
      num_errors++;
      give_verdict();
   endtask
   always @(posedge clk) begin
      if (axiRsp.bvalid && axiReq.bready || axiRsp.rvalid && axiReq.rready)
      begin
         mSeen = axiRsp.bvalid ? {axiRsp.bresp, 32'h0} :
            {axiRsp.rresp, axiRsp.rdata};
         if (noteQ.size() == 0) fail();
         mExp = noteQ.pop_front();
         mMask = maskQ.pop_front();
         if (mMask != 0) check(mSeen & mMask, mExp & mMask);
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
      input logic [1:0] r);
      int n;
      @(posedge clk);
      noteQ.push_back({r, 32'h0});
      maskQ.push_back({2'h3, 32'h0});
      axiReq.awaddr <= a;
      axiReq.wdata <= v;
      axiReq.wstrb <= 4'hf;
      axiReq.awvalid <= 1'b1;
      axiReq.wvalid <= 1'b1;
      axiReq.bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (axiRsp.awready) axiReq.awvalid <= 1'b0;
         if (axiRsp.wready) axiReq.wvalid <= 1'b0;
      end while (!axiRsp.bvalid && n < 64);
      if (n >= 64) fail();
      axiReq.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e,
      input logic [33:0] m, output logic [31:0] v);
      int n;
      @(posedge clk);
      noteQ.push_back(e);
      maskQ.push_back(m);
      axiReq.araddr <= a;
      axiReq.arvalid <= 1'b1;
      axiReq.rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (axiRsp.arready) axiReq.arvalid <= 1'b0;
      end while (!axiRsp.rvalid && n < 64);
      if (n >= 64) fail();
      v = axiRsp.rdata;
      axiReq.rready <= 1'b0;
   endtask
   task automatic mode(input logic [7:0] e, input logic [7:0] m);
      rd(REG_STATUS, {26'h0, e}, {2'h3, 24'h0, m}, d);
   endtask
   task automatic waitMode(input logic [2:0] md);
      int n;
      n = 0;
      do begin
         repeat (16) @(posedge clk);
         rd(REG_STATUS, 34'h0, 34'h0, d);
         n++;
      end while (d[2:0] !== md && n < 2500);
      if (n >= 2500) fail();
   endtask
   task automatic emitGap(output int gap);
      int n;
      n = 0;
      repeat (2) begin
         t0 = cyc;
         while (drv.infraredEmitterDrive && n < 20000) begin
            @(posedge clk);
            n++;
         end
         while (!drv.infraredEmitterDrive && n < 20000) begin
            @(posedge clk);
            n++;
         end
      end
      if (n >= 20000) fail();
      gap = cyc - t0;
   endtask
   task automatic watch(input int n);
      logic p;
      lamps = 0;
      horns = 0;
      p = drv.lampOe;
      repeat (n) begin
         @(posedge clk);
         lamps += int'(drv.lampOe && !p);
         p = drv.lampOe;
         horns += int'(drv.hornBrass | drv.hornSilver);
      end
   endtask
   task automatic hush();
      pinsDrv.btnMid <= 1'b1;
      repeat (32) @(posedge clk);
      pinsDrv.btnMid <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      pinsDrv.lowSupplyCmp <= 1'($random(seed));
      rd(REG_CTRL, 34'h0, {34{1'b1}}, d);
      mode(8'h00, 8'h07);
      rd(8'h08, {RESP_DECERR, 32'h0}, {34{1'b1}}, d);
      wr(8'h0c, 32'h2, RESP_DECERR);
      d = $random(seed);
      wr(REG_CTRL, d, RESP_OKAY);
      rd(REG_CTRL, {2'h0, d & 32'h2}, {34{1'b1}}, d);
      wr(REG_CTRL, 32'h0, RESP_OKAY);
      pinsDrv.smokeCmp <= 1'b1;
      waitMode(3'h1);
      check(34'(drv.ioOe), 34'h1);
      emitGap(t0);
      check(34'(t0), 34'(SPEEDUP_OSC * OSC));
      watch(4100);
      check(34'(lamps != 0 && horns != 0), 34'h1);
      hush();
      mode(8'h03, 8'h07);
      watch(300);
      check(34'(horns), 34'h0);
      waitMode(3'h1);
      hush();
      pinsDrv.highSmokeCmp <= 1'b1;
      t0 = cyc;
      waitMode(3'h1);
      // Must beat the hush timeout, so only the high-smoke exit passes
      check(34'(cyc - t0 < 280 * OSC), 34'h1);
      pinsDrv.highSmokeCmp <= 1'b0;
      hush();
      pinsDrv.smokeCmp <= 1'b0;
      waitMode(3'h0);
      hush();
      mode(8'h00, 8'h07);
      send <= 1'b1;
      waitMode(3'h2);
      watch(2100);
      check(34'(lamps), 34'h0);
      send <= 1'b0;
      waitMode(3'h0);
      send <= 1'b1;
      repeat (8) @(posedge clk);
      send <= 1'b0;
      repeat (5000) @(posedge clk);
      mode(8'h00, 8'h07);
      pinsDrv.smokeCmp <= 1'b1;
      waitMode(3'h1);
      pinsDrv.smokeCmp <= 1'b0;
      waitMode(3'h0);
      mode(8'h08, 8'h0f);
      pinsDrv.btnHigh <= 1'b1;
      waitMode(3'h7);
      watch(1100);
      check(34'(horns != 0), 34'h1);
      pinsDrv.btnHigh <= 1'b0;
      repeat (40) @(posedge clk);
      mode(8'h00, 8'h08);
      pinsDrv.smokeCmp <= 1'b1;
      pinsDrv.btnHigh <= 1'b1;
      waitMode(3'h6);
      emitGap(t0);
      check(34'(t0), 34'(TEST_PULSE_OSC * OSC));
      check(34'(drv.highGainSelect), 34'h1);
      repeat (2 * OSC) @(posedge clk);
      check(34'(drv.ioOe), 34'h1);
      check(34'(drv.ioOut), 34'h1);
      mode(8'h80, 8'h80);
      pinsDrv.btnHigh <= 1'b0;
      pinsDrv.smokeCmp <= 1'b0;
      repeat (3 * TEST_PULSE_OSC * OSC + 100) @(posedge clk);
      mode(8'h00, 8'h87);
      check(34'(drv.ioOe), 34'h0);
      check(34'(drv.highGainSelect), 34'h0);
      give_verdict();
   end
endmodule
